// file: core/cxe_exec.sv
// Execute unit for a subset of 8-bit core operations with an AHB-Lite register port
//
// Functional notes
// RULE_01: Clear working register, set zero flag only
// RULE_02: Call pushes current PC plus one
// RULE_03: Call loads immediate into PC bits 7:0
// RULE_04: Call takes PC 10:9 from page, bit 8 zero
// RULE_05: Call takes two cycles, flags untouched
// RULE_06: Watchdog clear zeroes watchdog counter
// RULE_07: Watchdog clear zeroes prescaler if watchdog-assigned
// RULE_08: Watchdog clear sets timeout and powerdown bits
// RULE_09: Clear file register, set zero flag
// RULE_10: Complement file register, zero flag only
// RULE_11: Destination bit picks working or file register
// RULE_12: Decrement file register, zero flag only
// RULE_13: Increment file register modulo 256, zero only
// RULE_14: Zero flag set when result is zero
// RULE_15: File operand is five-bit address, 32 locations
`timescale 1ns/1ps
`include "cxe_exec_regs.svh"
module cxe_exec #(
    parameter int STACK_DEPTH = 2,
    parameter int FILE_DEPTH = 32,
    parameter int PRESCALE_W = 8,
    parameter int PC_W = 11
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic exec_busy
);
    // Width of a file register index; the operand field is cut to it
    localparam int FA_W = $clog2(FILE_DEPTH);

    // Elaboration checks on the shape the logic relies on
    if (FILE_DEPTH != 32) begin : g_bad_file
        $error("cxe_exec: file space must hold 32 locations");
    end
    if (STACK_DEPTH < 1) begin : g_bad_stack
        $error("cxe_exec: return stack needs at least one level");
    end
    if (PC_W != 11) begin : g_bad_pc
        $error("cxe_exec: program counter must be 11 bits");
    end
    if (PRESCALE_W < 1 || PRESCALE_W > 16) begin : g_bad_pre
        $error("cxe_exec: prescaler width out of range");
    end

    // Bus address phase bookkeeping
    logic ap_valid_reg;
    logic ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic rd_wait_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;

    // Core state
    logic [7:0] work_reg;
    logic [7:0] status_reg;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] stack_reg [STACK_DEPTH];
    logic [7:0] file_mem [FILE_DEPTH];
    logic [7:0] wdog_reg;
    logic [PRESCALE_W-1:0] pre_reg;
    logic psa_reg;
    logic busy_reg;
    cxe_pkg::cxe_state_t state_reg;
    cxe_pkg::cxe_op_t last_op_reg;

    // Decoded command fields
    logic wr_en;
    logic issue;
    cxe_pkg::cxe_op_t cmd_op;
    logic [FA_W-1:0] cmd_faddr;
    logic [7:0] cmd_lit;
    logic wdog_tick;
    logic wdog_wrap;
    logic wdog_clear;
    logic pre_clear;

    cxe_alu_if alu_bus ();

    cxe_alu u_alu (
        .bus(alu_bus)
    );

    // Address compare shared by the write strobes
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_en && (ap_addr_reg == off);
    endfunction

    // File region decode: upper half of the window maps the 32 locations
    function automatic logic in_file(input logic [7:0] addr);
        in_file = addr[`CXE_FILE_BIT];
    endfunction

    // Address phase: take it whenever the bus is ready, we are selected and htrans[1] marks an active transfer
    wire ap_take = hsel && htrans[1] && hready;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= `CXE_ZERO_BYTE;
        end else begin
            ap_valid_reg <= ap_take;
            if (ap_take) begin
                ap_write_reg <= hwrite;
                ap_addr_reg <= {haddr[7:2], 2'b00}; // Word aligned, size is always a word
            end
        end
    end

    // Reads get one wait state so that a write landing just before is seen
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rd_wait_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
        end else begin
            rd_wait_reg <= ap_take && !hwrite;
            hreadyout_reg <= !(ap_take && !hwrite);
        end
    end

    // Read data mux; unmapped offsets read as zero with an OKAY answer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_wait_reg) begin
            hrdata_reg <= 32'h0000_0000;
            if (in_file(ap_addr_reg)) begin
                hrdata_reg[7:0] <= file_mem[ap_addr_reg[FA_W+1:2]];
            end else begin
                unique case (ap_addr_reg)
                    `CXE_OFF_WORK: hrdata_reg[7:0] <= work_reg;
                    `CXE_OFF_STATUS: hrdata_reg[7:0] <= status_reg;
                    `CXE_OFF_PC: hrdata_reg[PC_W-1:0] <= pc_reg;
                    `CXE_OFF_STACK: hrdata_reg[PC_W-1:0] <= stack_reg[0];
                    `CXE_OFF_WDOG: hrdata_reg[7:0] <= wdog_reg;
                    `CXE_OFF_CFG: begin
                        hrdata_reg[`CXE_CFG_PSA_BIT] <= psa_reg;
                        hrdata_reg[PRESCALE_W+7:8] <= pre_reg;
                    end
                    `CXE_OFF_INFO: begin
                        hrdata_reg[0] <= busy_reg;
                        hrdata_reg[`CXE_CMD_OP_LSB+2:`CXE_CMD_OP_LSB] <= last_op_reg;
                    end
                    default: hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Write data phase: writes never stall, so every write lands at its first data edge
    assign wr_en = ap_valid_reg && ap_write_reg;

    // A command is accepted only when the sequencer is idle; others are dropped
    // Process form so the signals read inside the decode function wake it up
    always_comb begin
        issue = wr_hit(`CXE_OFF_CMD) && (state_reg == cxe_pkg::CXE_ST_IDLE);
    end
    assign cmd_op = cxe_pkg::cxe_op_t'(hwdata[`CXE_CMD_OP_LSB+2:`CXE_CMD_OP_LSB]);
    assign cmd_faddr = hwdata[FA_W-1:0]; // RULE_15
    assign cmd_lit = hwdata[7:0];

    // Data path feed: the addressed file register is the operand
    assign alu_bus.op = issue ? cmd_op : cxe_pkg::CXE_OP_NOP;
    assign alu_bus.dest = hwdata[`CXE_CMD_DEST_BIT];
    assign alu_bus.operand = file_mem[cmd_faddr]; // RULE_15

    // Sequencer: the call holds the unit busy for its second instruction cycle
    // A command written during that second cycle is lost; software polls busy first
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= cxe_pkg::CXE_ST_IDLE;
            busy_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                cxe_pkg::CXE_ST_IDLE: begin
                    if (issue && cmd_op == cxe_pkg::CXE_OP_CALL) begin
                        state_reg <= cxe_pkg::CXE_ST_CALL2; // RULE_05
                        busy_reg <= 1'b1;
                    end
                end
                cxe_pkg::CXE_ST_CALL2: begin
                    state_reg <= cxe_pkg::CXE_ST_IDLE; // RULE_05
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // Last accepted operation, for software to inspect
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            last_op_reg <= cxe_pkg::CXE_OP_NOP;
        end else if (issue) begin
            last_op_reg <= cmd_op;
        end
    end

    // Working register: operation result beats nothing, as software cannot write alongside
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            work_reg <= `CXE_ZERO_BYTE;
        end else if (issue && alu_bus.to_work) begin
            work_reg <= alu_bus.result; // RULE_01 RULE_11
        end else if (wr_hit(`CXE_OFF_WORK)) begin
            work_reg <= hwdata[7:0];
        end
    end

    // File registers; reset to zero so reads are defined from the start
    // An operation write-back and a bus write never meet, as both need the one data phase
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_mem[i] <= `CXE_ZERO_BYTE;
            end
        end else if (issue && alu_bus.to_file) begin
            file_mem[cmd_faddr] <= alu_bus.result; // RULE_09 RULE_11
        end else if (wr_en && in_file(ap_addr_reg)) begin
            file_mem[ap_addr_reg[FA_W+1:2]] <= hwdata[7:0];
        end
    end

    // Status: zero flag per operation, watchdog bits set by clear, time-out bit cleared by time-out
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status_reg <= `CXE_STATUS_RST;
        end else begin
            if (wr_hit(`CXE_OFF_STATUS)) begin
                status_reg <= hwdata[7:0];
            end
            // Later assignments win: hardware beats software, a clear beats the wrap
            if (wdog_wrap) begin
                status_reg[`CXE_TIMEOUT_N_BIT] <= 1'b0;
            end
            if (issue && alu_bus.sets_zero) begin
                status_reg[`CXE_Z_BIT] <= alu_bus.zero; // RULE_01 RULE_09 RULE_14
            end
            if (wdog_clear) begin
                status_reg[`CXE_TIMEOUT_N_BIT] <= 1'b1; // RULE_08
                status_reg[`CXE_POWERDOWN_N_BIT] <= 1'b1; // RULE_08
            end
        end
    end

    // Program counter: call forms the target, every other operation steps by one
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pc_reg <= `CXE_PC_RST;
        end else if (issue && cmd_op == cxe_pkg::CXE_OP_CALL) begin
            // A call reaches only the lower half of a page, since bit 8 is forced low
            pc_reg[`CXE_PC_LIT_W-1:0] <= cmd_lit; // RULE_03
            pc_reg[`CXE_PC_LIT_W] <= 1'b0; // RULE_04
            pc_reg[`CXE_PC_PG_HI:`CXE_PC_PG_LO] <= status_reg[`CXE_PAGE_HI:`CXE_PAGE_LO];
        end else if (issue) begin
            pc_reg <= pc_reg + PC_W'(1);
        end else if (wr_hit(`CXE_OFF_PC)) begin
            pc_reg <= hwdata[PC_W-1:0];
        end
    end

    // Return stack: push shifts down, the oldest entry falls off the bottom
    // Only the top entry is visible on the bus; deeper ones are held but never read
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_reg[i] <= `CXE_PC_RST;
            end
        end else if (issue && cmd_op == cxe_pkg::CXE_OP_CALL) begin
            stack_reg[0] <= pc_reg + PC_W'(1); // RULE_02
            for (int i = 1; i < STACK_DEPTH; i++) begin
                stack_reg[i] <= stack_reg[i-1];
            end
        end
    end

    // Prescaler assignment: 1 hands the shared prescaler to the watchdog
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            psa_reg <= 1'b1;
        end else if (wr_hit(`CXE_OFF_CFG)) begin
            psa_reg <= hwdata[`CXE_CFG_PSA_BIT];
        end
    end

    // Watchdog clear and its conditional prescaler clear
    assign wdog_clear = issue && cmd_op == cxe_pkg::CXE_OP_WCLR;
    assign pre_clear = wdog_clear && psa_reg; // RULE_07

    // Without the prescaler the watchdog counts every clock
    assign wdog_tick = psa_reg ? (&pre_reg) : 1'b1;
    assign wdog_wrap = wdog_tick && (&wdog_reg) && !wdog_clear;

    // Shared prescaler runs freely; when given to the first timer it is not cleared here
    // After a clear with the prescaler given to the watchdog, the next watchdog tick is a full prescaler period away
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pre_reg <= '0;
        end else if (pre_clear) begin
            pre_reg <= '0; // RULE_07
        end else begin
            pre_reg <= pre_reg + PRESCALE_W'(1);
        end
    end

    // Watchdog counter; clear wins over a tick in the same cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wdog_reg <= `CXE_ZERO_BYTE;
        end else if (wdog_clear) begin
            wdog_reg <= `CXE_ZERO_BYTE; // RULE_06
        end else if (wdog_tick) begin
            wdog_reg <= wdog_reg + `CXE_ONE_BYTE;
        end
    end

    // Outputs straight from flip-flops; the response is always OKAY
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign exec_busy = busy_reg;

    // Transfer size is fixed to a word; the field is accepted but not checked
    wire unused_size = ^hsize;
endmodule

// file: include/cxe_exec_regs.svh
// Register offsets, field positions and reset values of the operation execute block
`ifndef CXE_EXEC_REGS_SVH
`define CXE_EXEC_REGS_SVH

// Byte offsets on the register bus
`define CXE_OFF_CMD 8'h00
`define CXE_OFF_WORK 8'h04
`define CXE_OFF_STATUS 8'h08
`define CXE_OFF_PC 8'h0c
`define CXE_OFF_STACK 8'h10
`define CXE_OFF_WDOG 8'h14
`define CXE_OFF_CFG 8'h18
`define CXE_OFF_INFO 8'h1c
`define CXE_FILE_BIT 7

// Command word layout
`define CXE_CMD_OP_LSB 16
`define CXE_CMD_DEST_BIT 8

// Operation codes
`define CXE_CODE_NOP 3'h0
`define CXE_CODE_CLEAR_WORKING 3'h1
`define CXE_CODE_CALL 3'h2
`define CXE_CODE_WCLR 3'h3
`define CXE_CODE_CLEAR_FILE 3'h4
`define CXE_CODE_COMP 3'h5
`define CXE_CODE_DEC 3'h6
`define CXE_CODE_INC 3'h7

// Status register fields
`define CXE_Z_BIT 2
`define CXE_POWERDOWN_N_BIT 3
`define CXE_TIMEOUT_N_BIT 4
`define CXE_PAGE_LO 5
`define CXE_PAGE_HI 6
`define CXE_STATUS_RST 8'h18

// Other values
`define CXE_ZERO_BYTE 8'h00
`define CXE_ONE_BYTE 8'h01
`define CXE_CFG_PSA_BIT 0
`define CXE_PC_RST 11'h000
`define CXE_PC_LIT_W 8
`define CXE_PC_PG_LO 9
`define CXE_PC_PG_HI 10

`endif

// file: include/cxe_pkg.sv
// Types shared by the operation execute block
`include "cxe_exec_regs.svh"
package cxe_pkg;
    typedef enum logic [2:0] {
        CXE_OP_NOP = `CXE_CODE_NOP,
        CXE_OP_CLEAR_WORKING = `CXE_CODE_CLEAR_WORKING,
        CXE_OP_CALL = `CXE_CODE_CALL,
        CXE_OP_WCLR = `CXE_CODE_WCLR,
        CXE_OP_CLEAR_FILE = `CXE_CODE_CLEAR_FILE,
        CXE_OP_COMP = `CXE_CODE_COMP,
        CXE_OP_DEC = `CXE_CODE_DEC,
        CXE_OP_INC = `CXE_CODE_INC
    } cxe_op_t;

    typedef enum logic {
        CXE_ST_IDLE,
        CXE_ST_CALL2
    } cxe_state_t;
endpackage

// file: include/cxe_alu_if.sv
// Carrier between the sequencer and the data path of the execute block
`timescale 1ns/1ps
interface cxe_alu_if;
    cxe_pkg::cxe_op_t op;
    logic dest;
    logic [7:0] operand;
    logic [7:0] result;
    logic zero;
    logic to_work;
    logic to_file;
    logic sets_zero;
    modport seq (output op, output dest, output operand,
                 input result, input zero, input to_work, input to_file, input sets_zero);
    modport alu (input op, input dest, input operand,
                 output result, output zero, output to_work, output to_file, output sets_zero);
endinterface

// file: core/cxe_alu.sv
// Data path of the file and working register operations
`timescale 1ns/1ps
`include "cxe_exec_regs.svh"
module cxe_alu (
    cxe_alu_if.alu bus
);
    // Result, destination and zero flag per operation
    always_comb begin
        bus.result = `CXE_ZERO_BYTE;
        bus.to_work = 1'b0;
        bus.to_file = 1'b0;
        bus.sets_zero = 1'b0;
        unique case (bus.op)
            cxe_pkg::CXE_OP_CLEAR_WORKING: begin
                bus.to_work = 1'b1; // RULE_01
                bus.sets_zero = 1'b1;
            end
            cxe_pkg::CXE_OP_CLEAR_FILE: begin
                bus.to_file = 1'b1; // RULE_09
                bus.sets_zero = 1'b1;
            end
            cxe_pkg::CXE_OP_COMP: begin
                bus.result = ~bus.operand; // RULE_10
                bus.sets_zero = 1'b1;
            end
            cxe_pkg::CXE_OP_DEC: begin
                bus.result = bus.operand - `CXE_ONE_BYTE; // RULE_12
                bus.sets_zero = 1'b1;
            end
            cxe_pkg::CXE_OP_INC: begin
                bus.result = bus.operand + `CXE_ONE_BYTE; // RULE_13
                bus.sets_zero = 1'b1;
            end
            default: begin
                bus.sets_zero = 1'b0; // Call, watchdog clear and no-op leave data alone
            end
        endcase
        // Selectable destination for the three read-modify-write forms
        if (bus.op == cxe_pkg::CXE_OP_COMP || bus.op == cxe_pkg::CXE_OP_DEC ||
            bus.op == cxe_pkg::CXE_OP_INC) begin
            bus.to_work = !bus.dest; // RULE_11
            bus.to_file = bus.dest; // RULE_11
        end
    end

    // Zero flag follows the eight-bit result; clears also give zero
    assign bus.zero = (bus.result == `CXE_ZERO_BYTE); // RULE_14
endmodule

// file: verif/cxe_exec_sva.sv
// Port-level bus and call-timing checks for the execute block
`timescale 1ns/1ps
`include "cxe_exec_regs.svh"
module cxe_exec_sva (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic exec_busy
);
    logic ph_wr;
    logic ph_rd;
    logic ph_cmd;
    logic taken;
    logic cmd_go;
    logic call_go;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Decode of the transfer now in its address phase and of the one in its data phase
    assign taken = hsel & htrans[1] & hready;
    assign cmd_go = ph_wr & ph_cmd & hready;
    assign call_go = cmd_go & (hwdata[18:16] == `CXE_CODE_CALL) & !exec_busy;
    // Address phase is only taken while hready is high, so latch then
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_cmd <= 1'b0;
        end else if (hready) begin
            ph_wr <= taken & hwrite;
            ph_rd <= taken & !hwrite;
            ph_cmd <= (haddr[7:2] == 6'h00);
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_read_one_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    a_wait_only_read: assert property (!hreadyout |-> ph_rd)
        else $error("wait state outside a read");
    a_rdata_hold: assert property (!ph_rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_call_busy: assert property (call_go |=> exec_busy)
        else $error("call did not take a second cycle");
    a_busy_pulse: assert property (exec_busy |=> !exec_busy)
        else $error("busy longer than one cycle");
    a_busy_cause: assert property ($rose(exec_busy) |-> $past(call_go))
        else $error("busy without a call");
    a_noncall_single: assert property (cmd_go && !call_go |=> !exec_busy)
        else $error("busy after a single-cycle operation");
    c_call: cover property (call_go);
    c_read: cover property (taken && !hwrite);
    c_wdog_clear: cover property (cmd_go && hwdata[18:16] == `CXE_CODE_WCLR);
endmodule

bind cxe_exec cxe_exec_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .exec_busy(exec_busy));

// file: verif/cxe_exec_tb.sv
// Self-checking bench for the operation execute block
`timescale 1ns/1ps
`include "cxe_exec_regs.svh"
module cxe_exec_tb;
    localparam logic [31:0] A_CMD = {24'h0, `CXE_OFF_CMD};
    localparam logic [31:0] A_WORK = {24'h0, `CXE_OFF_WORK};
    localparam logic [31:0] A_STAT = {24'h0, `CXE_OFF_STATUS};
    localparam logic [31:0] A_PC = {24'h0, `CXE_OFF_PC};
    localparam logic [31:0] A_STK = {24'h0, `CXE_OFF_STACK};
    localparam logic [31:0] A_WDOG = {24'h0, `CXE_OFF_WDOG};
    localparam logic [31:0] A_CFG = {24'h0, `CXE_OFF_CFG};
    localparam logic [31:0] A_INFO = {24'h0, `CXE_OFF_INFO};
    localparam logic [31:0] A_FILE = 32'h1 << `CXE_FILE_BIT;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic exec_busy;
    logic [31:0] rd;
    int n_fail = 0;
    int n_tests = 0;
    always #5 core_clk = ~core_clk;
    // Single slave, so its own ready is the bus ready
    cxe_exec u_dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exec_busy(exec_busy));
    // One single-word transfer; waits are unbounded here, only the timeout guard ends a hung one
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask
    function automatic logic [31:0] cmd(input logic [2:0] op, input logic d, input logic [7:0] k);
        return {13'h0, op, 7'h0, d, k};
    endfunction
    // File operation with Z preset, so a flag that never clears shows up
    task automatic fop(input logic [2:0] op, input logic d, input logic [4:0] f,
                       input logic [7:0] v);
        logic [7:0] r;
        logic [31:0] fa;
        logic to_f;
        fa = A_FILE + {25'h0, f, 2'b00};
        r = (op == 3'h5) ? ~v : (op == 3'h6) ? v - 8'h01 : (op == 3'h7) ? v + 8'h01 : 8'h00;
        to_f = d || (op == `CXE_CODE_CLEAR_FILE);
        bus(1'b1, fa, {24'h0, v});
        bus(1'b1, A_WORK, 32'h5a);
        bus(1'b1, A_STAT, 32'h64);
        bus(1'b1, A_CMD, cmd(op, d, {3'h0, f}));
        rchk("file", fa, {24'h0, to_f ? r : v});
        rchk("work", A_WORK, {24'h0, to_f ? 8'h5a : r});
        rchk("status", A_STAT, {24'h0, 8'h60 | (r == 8'h00 ? 8'h04 : 8'h00)});
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(1'b1, A_STAT, 32'h60);
        bus(1'b1, A_WORK, 32'ha5);
        bus(1'b1, A_CMD, cmd(`CXE_CODE_CLEAR_WORKING, 1'b0, 8'h00));
        rchk("work", A_WORK, 32'h0);
        rchk("status", A_STAT, 32'h64);
        rchk("info", A_INFO, {13'h0, `CXE_CODE_CLEAR_WORKING, 16'h0});
        // PC bit 8 starts set so a missing clear is seen
        bus(1'b1, A_PC, 32'h123);
        bus(1'b1, A_CMD, cmd(`CXE_CODE_CALL, 1'b0, 8'hab));
        // Busy is sampled mid-cycle, where it has settled
        @(negedge core_clk);
        check("busy", 32'h1, {31'h0, exec_busy});
        @(negedge core_clk);
        check("busy", 32'h0, {31'h0, exec_busy});
        rchk("pc", A_PC, 32'h6ab);
        rchk("stack", A_STK, 32'h124);
        rchk("status", A_STAT, 32'h64);
        bus(1'b1, A_STAT, 32'h20);
        bus(1'b1, A_CMD, cmd(`CXE_CODE_CALL, 1'b0, 8'h00));
        rchk("pc", A_PC, 32'h200);
        rchk("stack", A_STK, 32'h6ac);
        // A no-op only steps the program counter
        bus(1'b1, A_CMD, cmd(`CXE_CODE_NOP, 1'b0, 8'h00));
        rchk("pc", A_PC, 32'h201);
        fop(`CXE_CODE_COMP, 1'b1, 5'd0, 8'hff);
        fop(`CXE_CODE_COMP, 1'b0, 5'd31, 8'h0f);
        fop(`CXE_CODE_DEC, 1'b1, 5'd7, 8'h01);
        fop(`CXE_CODE_DEC, 1'b0, 5'd8, 8'h00);
        fop(`CXE_CODE_INC, 1'b1, 5'd31, 8'hff);
        fop(`CXE_CODE_INC, 1'b0, 5'd2, 8'h7f);
        fop(`CXE_CODE_CLEAR_FILE, 1'b0, 5'd31, 8'h99);
        bus(1'b1, 32'h40, 32'h77);
        rchk("unmapped", 32'h40, 32'h0);
        // Clear only while the prescaler is well away from zero
        bus(1'b1, A_STAT, 32'h00);
        do bus(1'b0, A_CFG, 32'h0); while (rd[15:8] < 8'h40 || rd[15:8] > 8'hc0);
        bus(1'b1, A_CMD, cmd(`CXE_CODE_WCLR, 1'b0, 8'h00));
        bus(1'b0, A_CFG, 32'h0);
        check("prescaler", 32'h1, {31'h0, rd[15:8] < 8'h10});
        rchk("status", A_STAT, 32'h18);
        rchk("wdog", A_WDOG, 32'h0);
        // Unprescaled watchdog runs every clock, so it is large before the clear
        bus(1'b1, A_CFG, 32'h0);
        repeat (60) @(posedge core_clk);
        bus(1'b1, A_CMD, cmd(`CXE_CODE_WCLR, 1'b0, 8'h00));
        bus(1'b0, A_WDOG, 32'h0);
        check("wdog", 32'h1, {31'h0, rd[7:0] < 8'h10});
        // Prescaler given to the first timer has run on since the earlier clear
        bus(1'b0, A_CFG, 32'h0);
        check("prescaler", 32'h1, {31'h0, rd[15:8] > 8'h40});
        final_report();
    end
    // Guard against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("unexpected timeout: expected done seen hung");
        final_report();
    end
endmodule
